// File: design/gscm_menu.sv
// Button-driven setup menu of the engine governor: response speed, setup codes and their editing screens.
`timescale 1ns/100ps
`default_nettype none
`include "gscm_consts.svh"

module gscm_menu #(
  parameter int unsigned HOLD_CYC = `GSCM_HOLD_MS * `GSCM_CLK_KHZ,
  parameter int unsigned TMO_CYC = `GSCM_TIMEOUT_MS * `GSCM_CLK_KHZ,
  parameter int unsigned ACC_CYC = `GSCM_ACCEPT_MS * `GSCM_CLK_KHZ,
  parameter int unsigned SHOW_CYC = `GSCM_BATT_SHOW_MS * `GSCM_CLK_KHZ
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Operator panel
  input wire gscm_pkg::gscm_btn_type buttons,
  // Engine and pump state
  input wire logic at_idle,
  input wire logic engine_running,
  input wire logic pump_interlock_closed,
  input wire logic all_interlocks_made,
  input wire logic engine_control_permit_lamp,
  input wire logic [15:0] stored_setpoint,
  input wire logic [15:0] engine_speed,
  input wire logic [7:0] battery_voltage,
  input wire logic [7:0] speed_request,
  input wire logic [3:0] nv_engine_type,
  // Displays and warnings
  output gscm_pkg::gscm_disp_type speed_disp,
  output gscm_pkg::gscm_disp_type press_disp,
  output logic low_batt_audible,
  output logic low_batt_visual,
  // Settings in effect, and the stored engine type
  output logic [2:0] response_level,
  output logic [3:0] engine_type_active,
  output logic [3:0] engine_type_stored,
  output logic [7:0] engine_control_level,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  // ****************************************
  // Reset release and button edges
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  gscm_pkg::gscm_btn_type btn_prev_q;
  gscm_pkg::gscm_btn_type rise;
  logic activity;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_prev_q <= '0;
    end else if (clk_en) begin
      btn_prev_q <= buttons;
    end
  end
  assign rise = buttons & ~btn_prev_q;
  assign activity = |rise;

  // ****************************************
  // Long alarm-mute hold
  // ****************************************
  logic [31:0] hold_q;
  logic hold_fire;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 32'h0;
    end else if (clk_en) begin
      if (!buttons.alarm_mute) begin
        hold_q <= 32'h0;
      end else if (hold_q < HOLD_CYC) begin
        hold_q <= hold_q + 32'h1;
      end
    end
  end
  assign hold_fire = buttons.alarm_mute && (hold_q == HOLD_CYC - 1);

  // ****************************************
  // Menu sequence
  // ****************************************
  gscm_pkg::gscm_state_type state_q, state_d;
  logic [31:0] tmr_q;
  logic [11:0] code_q;
  logic [1:0] sel_q;
  logic code_ok;
  logic code_bad;

  always_comb begin
    state_d = state_q;
    code_ok = 1'b0;
    code_bad = 1'b0;
    case (state_q)
      gscm_pkg::ST_NORMAL: begin
        if (hold_fire) begin
          state_d = gscm_pkg::ST_CODE;
        end else if (rise.setpoint && at_idle) begin
          state_d = gscm_pkg::ST_SETPT;
        end
      end
      gscm_pkg::ST_SETPT: begin
        if (!buttons.setpoint) begin
          state_d = gscm_pkg::ST_NORMAL;
        end else if (rise.rest) begin
          state_d = gscm_pkg::ST_RESP;
        end
      end
      gscm_pkg::ST_RESP: begin
        if (!buttons.setpoint) begin
          state_d = gscm_pkg::ST_NORMAL;
        end
      end
      gscm_pkg::ST_CODE: begin
        if (tmr_q >= TMO_CYC - 1) begin
          state_d = gscm_pkg::ST_NORMAL;
          code_bad = 1'b1;
        end else if (tmr_q == ACC_CYC - 1 && !activity) begin
          case (code_q)
            `GSCM_CODE_ENGINE: begin
              if (!pump_interlock_closed && !engine_control_permit_lamp && !engine_running) begin
                state_d = gscm_pkg::ST_ENG;
                code_ok = 1'b1;
              end else begin
                state_d = gscm_pkg::ST_NORMAL;
                code_bad = 1'b1;
              end
            end
            `GSCM_CODE_BATT_OFF: begin
              state_d = gscm_pkg::ST_BOFF;
              code_ok = 1'b1;
            end
            `GSCM_CODE_BATT_RUN: begin
              state_d = gscm_pkg::ST_BSHOW;
              code_ok = 1'b1;
            end
            `GSCM_CODE_IDLE_LEVEL: begin
              if (all_interlocks_made && engine_control_permit_lamp) begin
                state_d = gscm_pkg::ST_IDLEV;
                code_ok = 1'b1;
              end else begin
                state_d = gscm_pkg::ST_NORMAL;
                code_bad = 1'b1;
              end
            end
            default: begin
              state_d = gscm_pkg::ST_CODE;
            end
          endcase
        end
      end
      gscm_pkg::ST_BSHOW: begin
        if (hold_fire) begin
          state_d = gscm_pkg::ST_NORMAL;
        end else if (tmr_q >= SHOW_CYC - 1) begin
          state_d = gscm_pkg::ST_BRUN;
        end
      end
      gscm_pkg::ST_ENG, gscm_pkg::ST_BOFF, gscm_pkg::ST_BRUN, gscm_pkg::ST_IDLEV: begin
        if (hold_fire) begin
          state_d = gscm_pkg::ST_NORMAL;
        end
      end
      default: begin
        state_d = gscm_pkg::ST_NORMAL;
      end
    endcase
  end

  // The timer restarts on each state change and, in code entry, on each press.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= gscm_pkg::ST_NORMAL;
      tmr_q <= 32'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_d != state_q || (state_q == gscm_pkg::ST_CODE && activity)) begin
        tmr_q <= 32'h0;
      end else if (tmr_q != 32'hFFFFFFFF) begin
        tmr_q <= tmr_q + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 12'h000;
      sel_q <= 2'h0;
    end else if (clk_en) begin
      if (state_q != gscm_pkg::ST_CODE) begin
        code_q <= 12'h000;
        sel_q <= 2'h0;
      end else if (rise.speed_mode) begin
        sel_q <= (sel_q == 2'h2) ? 2'h0 : sel_q + 2'h1;
      end else if (rise.pressure_mode) begin
        for (int i = 0; i < 3; i++) begin
          if (sel_q == 2'(2 - i)) begin
            code_q[i*4 +: 4] <= (code_q[i*4 +: 4] == 4'h9) ? 4'h0 : code_q[i*4 +: 4] + 4'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // Stored settings
  // ****************************************
  logic [2:0] pend_q;
  logic [7:0] thr_off_q, thr_run_q, idle_q;
  logic loaded_q;

  function automatic logic [7:0] step(input logic [7:0] v, input logic up, input logic dn,
                                      input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] r;
    r = v;
    if (up && v < hi) begin
      r = v + 8'h01;
    end else if (dn && v > lo) begin
      r = v - 8'h01;
    end
    return r;
  endfunction : step

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      response_level <= `GSCM_RESP_DEFAULT;
      pend_q <= `GSCM_RESP_DEFAULT;
    end else if (clk_en) begin
      if (state_q == gscm_pkg::ST_SETPT) begin
        pend_q <= response_level;
      end else if (state_q == gscm_pkg::ST_RESP) begin
        pend_q <= 3'(step({5'h00, pend_q}, rise.raise, rise.lower, `GSCM_RESP_MIN, `GSCM_RESP_MAX));
        if (!buttons.setpoint) begin
          response_level <= pend_q;
        end
      end
    end
  end

  // The active engine type is sampled once after reset release, so edits wait for a power cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_q <= 1'b0;
      engine_type_active <= 4'h0;
      engine_type_stored <= 4'h0;
    end else if (clk_en) begin
      if (!loaded_q) begin
        loaded_q <= 1'b1;
        engine_type_active <= nv_engine_type;
        engine_type_stored <= nv_engine_type;
      end else if (state_q == gscm_pkg::ST_ENG) begin
        engine_type_stored <= 4'(step({4'h0, engine_type_stored}, rise.raise, rise.lower, 8'h00,
                                      `GSCM_ENG_TYPE_MAX));
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_off_q <= `GSCM_BATT_DEFAULT;
      thr_run_q <= `GSCM_BATT_DEFAULT;
      idle_q <= `GSCM_IDLE_DEFAULT;
    end else if (clk_en) begin
      if (state_q == gscm_pkg::ST_BOFF) begin
        thr_off_q <= step(thr_off_q, rise.raise, rise.lower, 8'h00, 8'hFF);
      end
      if (state_q == gscm_pkg::ST_BRUN) begin
        thr_run_q <= step(thr_run_q, rise.raise, rise.lower, 8'h00, 8'hFF);
      end
      if (state_q == gscm_pkg::ST_IDLEV) begin
        idle_q <= step(idle_q, rise.raise, rise.lower, 8'h00, 8'hFF);
      end
    end
  end

  // ****************************************
  // Control output and battery warning
  // ****************************************
  logic [8:0] ctrl_sum;
  logic batt_low;

  assign ctrl_sum = {1'b0, idle_q} + {1'b0, speed_request};
  assign batt_low = battery_voltage < (engine_running ? thr_run_q : thr_off_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_control_level <= `GSCM_IDLE_DEFAULT;
      low_batt_audible <= 1'b0;
      low_batt_visual <= 1'b0;
    end else if (clk_en) begin
      engine_control_level <= ctrl_sum[8] ? 8'hFF : ctrl_sum[7:0];
      low_batt_audible <= batt_low;
      low_batt_visual <= batt_low;
    end
  end

  // ****************************************
  // Displays
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_disp <= '0;
      press_disp <= '0;
    end else if (clk_en) begin
      press_disp <= '{gscm_pkg::DC_NORMAL, 16'h0000, 1'b0};
      case (state_q)
        gscm_pkg::ST_SETPT: begin
          speed_disp <= '{gscm_pkg::DC_VALUE, stored_setpoint, 1'b1};
          press_disp <= '{gscm_pkg::DC_PROMPT, 16'h0000, 1'b1};
        end
        gscm_pkg::ST_RESP: begin
          speed_disp <= '{gscm_pkg::DC_LEVEL, {13'h0000, pend_q}, 1'b0};
        end
        gscm_pkg::ST_CODE: begin
          speed_disp <= '{gscm_pkg::DC_DASHES, {2'h0, sel_q, code_q}, 1'b0};
        end
        gscm_pkg::ST_ENG: begin
          speed_disp <= '{gscm_pkg::DC_VALUE, {12'h000, engine_type_stored}, 1'b1};
        end
        gscm_pkg::ST_BOFF: begin
          speed_disp <= '{gscm_pkg::DC_VALUE, {8'h00, thr_off_q}, 1'b0};
        end
        gscm_pkg::ST_BSHOW: begin
          speed_disp <= '{gscm_pkg::DC_VALUE, {8'h00, battery_voltage}, 1'b1};
        end
        gscm_pkg::ST_BRUN: begin
          speed_disp <= '{gscm_pkg::DC_VALUE, {8'h00, thr_run_q}, 1'b0};
        end
        gscm_pkg::ST_IDLEV: begin
          speed_disp <= '{gscm_pkg::DC_VALUE, engine_speed, 1'b0};
        end
        default: begin
          speed_disp <= '{gscm_pkg::DC_NORMAL, engine_speed, 1'b0};
        end
      endcase
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  logic [`GSCM_ST_WIDTH-1:0] status_q, mask_q, events;
  logic batt_low_q;

  assign events[`GSCM_ST_RESP_STORED] = state_q == gscm_pkg::ST_RESP && !buttons.setpoint;
  assign events[`GSCM_ST_CODE_OK] = code_ok;
  assign events[`GSCM_ST_CODE_BAD] = code_bad;
  assign events[`GSCM_ST_LOW_BATT] = batt_low && !batt_low_q;

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      mask_q <= '0;
      batt_low_q <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      batt_low_q <= batt_low;
      if (reg_wr && reg_addr == `GSCM_OFS_STATUS) begin
        status_q <= (status_q & ~reg_wdata[`GSCM_ST_WIDTH-1:0]) | events;
      end else begin
        status_q <= status_q | events;
      end
      if (reg_wr && reg_addr == `GSCM_OFS_MASK) begin
        mask_q <= reg_wdata[`GSCM_ST_WIDTH-1:0];
      end
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `GSCM_OFS_STATUS: reg_rdata <= {28'h0, status_q};
          `GSCM_OFS_MASK: reg_rdata <= {28'h0, mask_q};
          `GSCM_OFS_SETTINGS: reg_rdata <= {12'h0, engine_type_active, 4'h0, engine_type_stored, 5'h0, response_level};
          `GSCM_OFS_THRESH: reg_rdata <= {16'h0, thr_run_q, thr_off_q};
          `GSCM_OFS_IDLE: reg_rdata <= {24'h0, idle_q};
          `GSCM_OFS_MENU: reg_rdata <= {28'h0, state_q};
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  level_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    response_level >= 3'h1 && response_level <= 3'h5) else $error("response level out of range");
  arm_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_q == gscm_pkg::ST_NORMAL && hold_fire |=> state_q == gscm_pkg::ST_CODE ##1
    speed_disp.content == gscm_pkg::DC_DASHES) else $error("long hold did not arm code entry");
  code_timeout_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == gscm_pkg::ST_CODE |-> tmr_q < TMO_CYC) else $error("code entry outlived timeout");
  level_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_q == gscm_pkg::ST_RESP && !buttons.setpoint |=>
    response_level == $past(pend_q) && state_q == gscm_pkg::ST_NORMAL) else $error("level not stored");
  level_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_q == gscm_pkg::ST_RESP && rise.raise && pend_q < 3'h5 |=>
    pend_q == $past(pend_q) + 3'h1) else $error("raise did not step level");
  type_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    loaded_q |=> $stable(engine_type_active)) else $error("engine type changed without power cycle");
  engine_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q != gscm_pkg::ST_ENG ##1 state_q == gscm_pkg::ST_ENG |->
    $past(!engine_running && !pump_interlock_closed)) else $error("engine type entered while unsafe");
  idle_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q != gscm_pkg::ST_IDLEV ##1 state_q == gscm_pkg::ST_IDLEV |->
    $past(all_interlocks_made && engine_control_permit_lamp)) else $error("idle level entered while unsafe");
  ctrl_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && speed_request != 8'h00 && idle_q != 8'hFF |=> engine_control_level > $past(idle_q))
    else $error("control output did not rise");
  discard_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    code_bad |=> $stable(thr_off_q) && $stable(thr_run_q) && $stable(idle_q)) else $error("setting changed");
  irq_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> irq == $past(|(status_q & mask_q))) else $error("interrupt mismatch");
endmodule : gscm_menu
`default_nettype wire

// File: design/gscm_consts.svh
// Constants of the governor setup code menu: offsets, reset values, codes and times.
`ifndef GSCM_CONSTS_SVH
`define GSCM_CONSTS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define GSCM_OFS_STATUS 8'h00
`define GSCM_OFS_MASK 8'h04
`define GSCM_OFS_SETTINGS 8'h08
`define GSCM_OFS_THRESH 8'h0C
`define GSCM_OFS_IDLE 8'h10
`define GSCM_OFS_MENU 8'h14
// ****************************************
// Status bit positions
// ****************************************
`define GSCM_ST_RESP_STORED 0
`define GSCM_ST_CODE_OK 1
`define GSCM_ST_CODE_BAD 2
`define GSCM_ST_LOW_BATT 3
`define GSCM_ST_WIDTH 4
// ****************************************
// Reset values and limits
// ****************************************
`define GSCM_RESP_DEFAULT 3'h3
`define GSCM_RESP_MIN 8'h01
`define GSCM_RESP_MAX 8'h05
`define GSCM_ENG_TYPE_MAX 8'h06
`define GSCM_BATT_DEFAULT 8'h75
`define GSCM_IDLE_DEFAULT 8'h3C
// ****************************************
// Setup codes, three BCD digits
// ****************************************
`define GSCM_CODE_ENGINE 12'h441
`define GSCM_CODE_BATT_OFF 12'h417
`define GSCM_CODE_BATT_RUN 12'h418
`define GSCM_CODE_IDLE_LEVEL 12'h436
// ****************************************
// Times
// ****************************************
`define GSCM_CLK_KHZ 20000
`define GSCM_HOLD_MS 5000
`define GSCM_TIMEOUT_MS 3000
`define GSCM_ACCEPT_MS 2000
`define GSCM_BATT_SHOW_MS 20000
`endif

// File: design/gscm_pkg.sv
// Types of the governor setup code menu.
package gscm_pkg;
  typedef enum logic [3:0] {
    ST_NORMAL, ST_SETPT, ST_RESP, ST_CODE, ST_ENG, ST_BOFF, ST_BSHOW, ST_BRUN, ST_IDLEV
  } gscm_state_type;

  typedef enum logic [2:0] {
    DC_NORMAL, DC_DASHES, DC_PROMPT, DC_VALUE, DC_LEVEL
  } gscm_content_type;

  typedef struct packed {
    logic setpoint;
    logic rest;
    logic raise;
    logic lower;
    logic alarm_mute;
    logic speed_mode;
    logic pressure_mode;
  } gscm_btn_type;

  typedef struct packed {
    gscm_content_type content;
    logic [15:0] value;
    logic flash;
  } gscm_disp_type;
endpackage : gscm_pkg

// File: testbench/gscm_panel.sv
// Operator panel model: the push buttons that the bench presses.
`timescale 1ns/100ps
`default_nettype none
module gscm_panel (
  // Clock
  input wire logic ref_clk,
  // Button levels
  output var gscm_pkg::gscm_btn_type buttons
);
  initial buttons = '0;
  // Levels change only just after an edge, so one rise is one press.
  task automatic set(input int b, input logic v);
    @(posedge ref_clk);
    buttons[b] <= v;
  endtask : set
  task automatic tap(input int b, input int n);
    repeat (n) begin
      set(b, 1'b1);
      set(b, 1'b0);
    end
  endtask : tap
  task automatic hold(input int b, input int n);
    set(b, 1'b1);
    repeat (n) @(posedge ref_clk);
    buttons[b] <= 1'b0;
  endtask : hold
endmodule : gscm_panel
`default_nettype wire

// File: testbench/gscm_menu_test.sv
// Self-checking bench of the setup code menu.
`timescale 1ns/100ps
`default_nettype none
`include "gscm_consts.svh"
module gscm_menu_test;
  localparam int HOLD = 20;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic at_idle = 1'b1;
  logic engine_running = 1'b0;
  logic pump_interlock_closed = 1'b0;
  logic all_interlocks_made = 1'b0;
  logic engine_control_permit_lamp = 1'b0;
  logic [15:0] stored_setpoint = 16'h0123;
  logic [15:0] engine_speed = 16'h1234;
  logic [7:0] battery_voltage = 8'h80;
  logic [7:0] speed_request = 8'h00;
  logic [3:0] nv_engine_type = 4'h2;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gscm_pkg::gscm_btn_type buttons;
  gscm_pkg::gscm_disp_type speed_disp, press_disp;
  logic low_batt_audible, low_batt_visual, irq;
  logic [2:0] response_level;
  logic [3:0] engine_type_active, engine_type_stored;
  logic [7:0] engine_control_level;
  logic [31:0] reg_rdata;
  int fail_count = 0;
  int n_tests = 0;

  always #25 ref_clk = ~ref_clk;

  gscm_panel panel_inst (.ref_clk, .buttons);
  gscm_menu #(.HOLD_CYC(HOLD), .TMO_CYC(12), .ACC_CYC(8), .SHOW_CYC(40)) gscm_menu_inst (
    .ref_clk, .arst_n, .clk_en, .buttons, .at_idle, .engine_running, .pump_interlock_closed,
    .all_interlocks_made, .engine_control_permit_lamp, .stored_setpoint, .engine_speed,
    .battery_voltage, .speed_request, .nv_engine_type, .speed_disp, .press_disp,
    .low_batt_audible, .low_batt_visual, .response_level, .engine_type_active,
    .engine_type_stored, .engine_control_level, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rdc
  task automatic code(input int a, input int b, input int c);
    panel_inst.hold(2, HOLD + 4);
    panel_inst.tap(0, a);
    panel_inst.tap(1, 1);
    panel_inst.tap(0, b);
    panel_inst.tap(1, 1);
    panel_inst.tap(0, c);
    wt(10);
  endtask : code
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end

  initial begin
    wt(2);
    arst_n <= 1'b1;
    wt(4);
    chk(response_level, 3'h3);
    chk(engine_type_active, 4'h2);
    chk(engine_control_level, 8'h3C);
    rdc(`GSCM_OFS_THRESH, 32'h7575);
    rdc(8'h40, 32'h0);
    clk_en <= 1'b0;
    speed_request <= 8'h05;
    wt(3);
    chk(engine_control_level, 8'h3C);
    clk_en <= 1'b1;
    speed_request <= 8'h05;
    battery_voltage <= 8'h70;
    wt(3);
    chk(engine_control_level, 8'h41);
    chk(low_batt_visual, 1'b1);
    chk(low_batt_audible, 1'b1);
    speed_request <= 8'h00;
    battery_voltage <= 8'h80;
    wr(`GSCM_OFS_MASK, 32'h1);
    panel_inst.set(6, 1'b1);
    wt(3);
    chk(speed_disp.flash, 1'b1);
    chk(press_disp.content, gscm_pkg::DC_PROMPT);
    panel_inst.tap(5, 1);
    rdc(`GSCM_OFS_MENU, 32'h2);
    panel_inst.tap(4, 4);
    panel_inst.tap(3, 1);
    panel_inst.set(6, 1'b0);
    wt(3);
    chk(response_level, 3'h4);
    chk(irq, 1'b1);
    wr(`GSCM_OFS_STATUS, 32'h1);
    wt(3);
    chk(irq, 1'b0);
    panel_inst.hold(2, HOLD + 4);
    wt(1);
    chk(speed_disp.content, gscm_pkg::DC_DASHES);
    wt(14);
    rdc(`GSCM_OFS_MENU, 32'h0);
    code(4, 4, 1);
    rdc(`GSCM_OFS_MENU, 32'h4);
    chk(speed_disp.flash, 1'b1);
    wt(16);
    rdc(`GSCM_OFS_MENU, 32'h4);
    panel_inst.tap(4, 1);
    wt(2);
    chk(engine_type_stored, 4'h3);
    panel_inst.hold(2, HOLD + 4);
    rdc(`GSCM_OFS_MENU, 32'h0);
    chk(engine_type_active, 4'h2);
    rdc(`GSCM_OFS_SETTINGS, 32'h00020304);
    engine_running <= 1'b1;
    code(4, 4, 1);
    rdc(`GSCM_OFS_MENU, 32'h0);
    code(4, 3, 6);
    rdc(`GSCM_OFS_MENU, 32'h0);
    all_interlocks_made <= 1'b1;
    pump_interlock_closed <= 1'b1;
    engine_control_permit_lamp <= 1'b1;
    code(4, 3, 6);
    rdc(`GSCM_OFS_MENU, 32'h8);
    chk(speed_disp.value, 16'h1234);
    panel_inst.tap(4, 1);
    wt(2);
    chk(engine_control_level, 8'h3D);
    panel_inst.hold(2, HOLD + 4);
    rdc(`GSCM_OFS_IDLE, 32'h3D);
    code(4, 1, 7);
    rdc(`GSCM_OFS_MENU, 32'h5);
    panel_inst.tap(3, 1);
    panel_inst.hold(2, HOLD + 4);
    rdc(`GSCM_OFS_THRESH, 32'h7574);
    code(4, 1, 8);
    rdc(`GSCM_OFS_MENU, 32'h6);
    chk(speed_disp.flash, 1'b1);
    wt(44);
    rdc(`GSCM_OFS_MENU, 32'h7);
    panel_inst.hold(2, HOLD + 4);
    code(1, 2, 3);
    wt(6);
    rdc(`GSCM_OFS_MENU, 32'h0);
    rdc(`GSCM_OFS_THRESH, 32'h7574);
    nv_engine_type <= 4'h3;
    arst_n <= 1'b0;
    wt(2);
    arst_n <= 1'b1;
    wt(4);
    chk(engine_type_active, 4'h3);
    chk(response_level, 3'h3);
    conclude();
  end
endmodule : gscm_menu_test
`default_nettype wire
